// ===== core/spefe_regs.vh
// constants for the serial flash program and erase engine
`ifndef SPEFE_REGS_VH
`define SPEFE_REGS_VH
`define SPEFE_OP_PROG     8'h02
`define SPEFE_OP_PG_ERASE 8'h81
`define SPEFE_OP_BLK4     8'h20
`define SPEFE_OP_BLK32A   8'h52
`define SPEFE_OP_BLK32B   8'hD8
`define SPEFE_ERASED      8'hFF
`define SPEFE_PAGE_BYTES  256
`define SPEFE_ADDR_BYTES  4'h4
`define SPEFE_CLK_MHZ     20
`define SPEFE_SIZE_PAGE   2'h0
`define SPEFE_SIZE_4K     2'h1
`define SPEFE_SIZE_32K    2'h2
`define SPEFE_MASK_PAGE   16'hFF00
`define SPEFE_MASK_4K     16'hF000
`define SPEFE_MASK_32K    16'h8000
// self-timed cycle lengths in microseconds, plain defaults
`define SPEFE_BYTE_PROGRAM_TIME_US 10
`define SPEFE_PAGE_PROGRAM_TIME_US 1000
`define SPEFE_PAGE_ERASE_TIME_US   10000
`define SPEFE_BLOCK_ERASE_TIME_US  100000
`define SPEFE_BP_CYC  (`SPEFE_BYTE_PROGRAM_TIME_US * `SPEFE_CLK_MHZ)
`define SPEFE_PP_CYC  (`SPEFE_PAGE_PROGRAM_TIME_US * `SPEFE_CLK_MHZ)
`define SPEFE_PE_CYC  (`SPEFE_PAGE_ERASE_TIME_US * `SPEFE_CLK_MHZ)
`define SPEFE_BLK_CYC (`SPEFE_BLOCK_ERASE_TIME_US * `SPEFE_CLK_MHZ)
`endif

// ===== core/spefe_sync.v
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module spefe_sync #(
  parameter W = 1
) (
  input  wire         clock,  // system clock
  input  wire         sys_rst,// sync reset
  input  wire [W-1:0] d,      // asynchronous inputs
  input  wire [W-1:0] rst_val,// constant value under reset
  output reg  [W-1:0] q       // synchronised outputs
);
  reg [W-1:0] meta_ff;
  always @(posedge clock) begin
    if (sys_rst) begin
      meta_ff <= rst_val;
      q       <= rst_val;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule // spefe_sync
`default_nettype wire

// ===== core/spefe_buf2.v
// two-entry valid/ready buffer
`timescale 1ns/1ns
`default_nettype none
module spefe_buf2 #(
  parameter W = 8
) (
  input  wire         clock,     // system clock
  input  wire         sys_rst,   // sync reset
  input  wire         in_valid,  // word offered
  output wire         in_ready,  // room for a word
  input  wire [W-1:0] in_data,   // offered word
  output wire         out_valid, // word available
  input  wire         out_ready, // drain takes word
  output wire [W-1:0] out_data   // oldest word
);
  reg [W-1:0] ent_ff [0:1];
  reg [1:0]   cnt_ff;
  reg         rd_ff;
  reg         wr_ff;
  wire        push = in_valid & in_ready;
  wire        pop  = out_valid & out_ready;
  assign in_ready  = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign out_data  = ent_ff[rd_ff];
  always @(posedge clock) begin
    if (sys_rst) begin
      cnt_ff <= 2'h0;
      rd_ff  <= 1'b0;
      wr_ff  <= 1'b0;
    end else begin
      if (push) begin
        ent_ff[wr_ff] <= in_data;
        wr_ff         <= ~wr_ff;
      end
      if (pop)
        rd_ff <= ~rd_ff;
      if (push & ~pop)
        cnt_ff <= cnt_ff + 2'h1;
      else if (pop & ~push)
        cnt_ff <= cnt_ff - 2'h1;
    end
  end
endmodule // spefe_buf2
`default_nettype wire

// ===== core/spefe_engine.v
// serial flash program and erase command engine
// Functional notes
// (RULE1) program is 02h, three address bytes, data
// (RULE2) program needs write latch set first
// (RULE3) program writes 1 to 256 erased bytes
// (RULE4) unaligned data wraps inside same page
// (RULE5) over 256 bytes keeps last 256
// (RULE6) program buffer at release; untouched bytes stay
// (RULE7) abort without full address, data, byte alignment
// (RULE8) protected array ignores program command
// (RULE9) program abort clears write latch flag
// (RULE10) busy during program; latch cleared before end
// (RULE11) host polls busy instead of waiting
// (RULE12) program failure sets fail flag
// (RULE13) page erase 81h, dummy, page index, dummy
// (RULE14) page erase sets page to ones, busy
// (RULE15) block erase 20h 4K, 52h/D8h 32K
// (RULE16) block erase needs write latch set
// (RULE17) block erase ignores low address bits
// (RULE18) block erase aborts without full address, alignment
// (RULE19) protected array ignores block erase
// (RULE20) block erase abort clears write latch flag
// (RULE21) busy during block erase; latch cleared
// (RULE22) erase failure sets fail flag
// (RULE23) no program or erase without write latch
// (RULE24) protect bit 1 blocks all program/erase
// (RULE25) incomplete page erase aborts, clears latch
`timescale 1ns/1ns
`default_nettype none
`include "spefe_regs.vh"
module spefe_engine #(
  parameter BP_CYC  = `SPEFE_BP_CYC,
  parameter PP_CYC  = `SPEFE_PP_CYC,
  parameter PE_CYC  = `SPEFE_PE_CYC,
  parameter BLK_CYC = `SPEFE_BLK_CYC
) (
  input  wire        clock,             // 20 MHz system clock
  input  wire        sys_rst,           // sync reset, active high
  input  wire        sck,               // serial clock pin
  input  wire        cs_n,              // chip select pin, active low
  input  wire        si,                // serial data in pin
  input  wire        write_latch_flag,  // latch state from status logic
  input  wire        array_protect_bit, // 1 protects whole array
  input  wire        arr_ack,           // array finished request
  input  wire        arr_ok,            // array verify result
  output reg         wel_clear_ff,      // pulse: clear write latch
  output reg         busy_ff,           // self-timed cycle running
  output reg         pe_fail_ff,        // program_erase_fail_flag
  output reg         arr_req_ff,        // array request
  output reg         arr_erase_ff,      // 1 erase, 0 program byte
  output reg  [1:0]  arr_size_ff,       // erase size code
  output reg  [15:0] arr_addr_ff,       // array byte address
  output reg  [7:0]  arr_data_ff        // program data
);
  localparam S_RX   = 5'h01;
  localparam S_PROG = 5'h02;
  localparam S_PWT  = 5'h04;
  localparam S_ERS  = 5'h08;
  localparam S_TIME = 5'h10;

  // counts cut to the timer width on purpose, so an oversized override wraps silently to its low 32 bits
  localparam [31:0] BP_T     = BP_CYC;
  localparam [31:0] PP_T     = PP_CYC;
  localparam [31:0] PE_T     = PE_CYC;
  localparam [31:0] BLK_T    = BLK_CYC;
  localparam [8:0]  PAGE_END = `SPEFE_PAGE_BYTES;

  wire [2:0] pin_s;
  spefe_sync #(.W(3)) u_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .d       ({sck, cs_n, si}),
    .rst_val (3'h2),
    .q       (pin_s)
  );
  wire sck_s = pin_s[2];
  wire cs_s  = pin_s[1];
  wire si_s  = pin_s[0];

  reg        sck_d_ff;
  reg        cs_d_ff;
  reg        live_ff;
  reg [2:0]  bit_ff;
  reg [7:0]  sh_ff;
  reg        hold_v_ff;
  reg [7:0]  hold_d_ff;
  reg        end_ff;
  reg        align_ff;
  reg [4:0]  st_ff;
  reg [3:0]  nb_ff;
  reg [8:0]  ndata_ff;
  reg [7:0]  op_ff;
  reg [23:0] addr_ff;
  reg [7:0]  wptr_ff;
  reg [7:0]  page_mem [0:255];
  reg [255:0] map_ff;
  reg [8:0]  idx_ff;
  reg [31:0] tmr_ff;
  reg [31:0] tgt_ff;

  wire sck_rise = sck_s & ~sck_d_ff;
  wire cs_fall  = ~cs_s & cs_d_ff;
  wire cs_rise  = cs_s & ~cs_d_ff;
  wire st_rx    = (st_ff == S_RX);
  wire b_in_rdy;
  wire b_out_v;
  wire [7:0] b_out_d;

  // frames that open while busy are ignored whole so no tail is misparsed
  always @(posedge clock) begin
    if (sys_rst) begin
      sck_d_ff  <= 1'b0;
      cs_d_ff   <= 1'b1;
      live_ff   <= 1'b0;
      bit_ff    <= 3'h0;
      sh_ff     <= 8'h00;
      hold_v_ff <= 1'b0;
      hold_d_ff <= 8'h00;
      align_ff  <= 1'b0;
    end else begin
      sck_d_ff <= sck_s;
      cs_d_ff  <= cs_s;
      if (cs_fall) begin
        live_ff <= st_rx;
        bit_ff  <= 3'h0;
      end else if (cs_rise) begin
        live_ff  <= 1'b0;
        align_ff <= (bit_ff == 3'h0); // [RULE7] [RULE18] [RULE25]
      end else if (live_ff & sck_rise) begin
        sh_ff  <= {sh_ff[6:0], si_s};
        bit_ff <= bit_ff + 3'h1;
      end
      if (hold_v_ff & b_in_rdy)
        hold_v_ff <= 1'b0;
      // a byte that meets a full buffer and a full hold stage overwrites the held byte, which is lost
      if (live_ff & sck_rise & ~cs_fall & ~cs_rise & (bit_ff == 3'h7)) begin
        hold_v_ff <= 1'b1;
        hold_d_ff <= {sh_ff[6:0], si_s};
      end
    end
  end

  spefe_buf2 #(.W(8)) u_buf (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .in_valid  (hold_v_ff),
    .in_ready  (b_in_rdy),
    .in_data   (hold_d_ff),
    .out_valid (b_out_v),
    .out_ready (st_rx),
    .out_data  (b_out_d)
  );

  wire is_prog = (op_ff == `SPEFE_OP_PROG);
  wire is_pe   = (op_ff == `SPEFE_OP_PG_ERASE);
  wire is_b4   = (op_ff == `SPEFE_OP_BLK4);
  wire is_b32  = (op_ff == `SPEFE_OP_BLK32A) | (op_ff == `SPEFE_OP_BLK32B);
  wire is_ers  = is_pe | is_b4 | is_b32;
  wire eval    = st_rx & end_ff & ~b_out_v & ~hold_v_ff;
  wire got_adr = (nb_ff >= `SPEFE_ADDR_BYTES);
  wire got_dat = (ndata_ff != 9'h000);
  wire len_ok  = is_prog ? (got_adr & got_dat) : got_adr; // [RULE7] [RULE18] [RULE25]
  wire run     = write_latch_flag & ~array_protect_bit & align_ff & len_ok; // [RULE2] [RULE16] [RULE23] [RULE24]
  wire [15:0] ers_mask = is_pe ? `SPEFE_MASK_PAGE :
                         is_b4 ? `SPEFE_MASK_4K : `SPEFE_MASK_32K; // [RULE17]
  wire [1:0]  ers_size = is_pe ? `SPEFE_SIZE_PAGE :
                         is_b4 ? `SPEFE_SIZE_4K : `SPEFE_SIZE_32K; // [RULE15]
  wire [7:0]  idx8     = idx_ff[7:0];
  wire [7:0]  prog_off = addr_ff[7:0] + idx8;

  always @(posedge clock) begin
    if (sys_rst)
      end_ff <= 1'b0;
    else if (cs_rise & live_ff)
      end_ff <= 1'b1;
    else if (eval | ~st_rx)
      end_ff <= 1'b0;
  end

  // the byte stream is parsed in the same process that launches the cycle
  always @(posedge clock) begin
    if (sys_rst) begin
      st_ff        <= S_RX;
      nb_ff        <= 4'h0;
      ndata_ff     <= 9'h000;
      op_ff        <= 8'h00;
      addr_ff      <= 24'h000000;
      wptr_ff      <= 8'h00;
      map_ff       <= 256'h0;
      idx_ff       <= 9'h000;
      tmr_ff       <= 32'h00000000;
      tgt_ff       <= 32'h00000000;
      wel_clear_ff <= 1'b0;
      busy_ff      <= 1'b0;
      pe_fail_ff   <= 1'b0;
      arr_req_ff   <= 1'b0;
      arr_erase_ff <= 1'b0;
      arr_size_ff  <= `SPEFE_SIZE_PAGE;
      arr_addr_ff  <= 16'h0000;
      arr_data_ff  <= 8'h00;
    end else begin
      wel_clear_ff <= 1'b0;
      if (~st_rx)
        tmr_ff <= tmr_ff + 32'h00000001;
      case (st_ff)
        S_RX: begin
          if (b_out_v) begin
            if (nb_ff == 4'h0) begin
              op_ff  <= b_out_d;
              map_ff <= 256'h0;
            end else if (nb_ff < `SPEFE_ADDR_BYTES) begin
              addr_ff <= {addr_ff[15:0], b_out_d}; // [RULE1] [RULE13]
            end
            if (nb_ff == 4'h3)
              wptr_ff <= b_out_d;
            if (nb_ff != 4'hF)
              nb_ff <= nb_ff + 4'h1;
            if (got_adr & is_prog) begin
              page_mem[wptr_ff] <= b_out_d; // [RULE1] [RULE5]
              map_ff[wptr_ff]   <= 1'b1;
              wptr_ff           <= wptr_ff + 8'h01; // [RULE4]
              if (ndata_ff != PAGE_END)
                ndata_ff <= ndata_ff + 9'h001;
            end
          end
          if (eval) begin
            nb_ff    <= 4'h0;
            ndata_ff <= 9'h000;
            tmr_ff   <= 32'h00000000;
            idx_ff   <= 9'h000;
            // a frame cut inside its opcode byte must not reuse the last opcode
            op_ff    <= 8'h00;
            // the clear matters only while the latch is set, so a refused frame without it leaves no trace
            if ((is_prog | is_ers) & write_latch_flag & ~run)
              wel_clear_ff <= 1'b1; // [RULE8] [RULE9] [RULE19] [RULE20] [RULE25]
            if (run & is_prog) begin
              st_ff        <= S_PROG; // [RULE6]
              busy_ff      <= 1'b1;   // [RULE10]
              pe_fail_ff   <= 1'b0;
              wel_clear_ff <= 1'b1;   // [RULE10]
              tgt_ff       <= (ndata_ff == 9'h001) ? BP_T : PP_T;
            end else if (run & is_ers) begin
              st_ff        <= S_ERS;  // [RULE14]
              busy_ff      <= 1'b1;   // [RULE14] [RULE21]
              pe_fail_ff   <= 1'b0;
              wel_clear_ff <= 1'b1;   // [RULE21]
              arr_req_ff   <= 1'b1;
              arr_erase_ff <= 1'b1;
              arr_size_ff  <= ers_size;
              arr_addr_ff  <= addr_ff[15:0] & ers_mask; // [RULE17]
              tgt_ff       <= is_pe ? PE_T : BLK_T;
            end
          end
        end
        S_PROG: begin
          // bytes never sent are skipped so they stay erased
          if (idx_ff == PAGE_END) begin
            st_ff <= S_TIME;
          end else if (map_ff[prog_off]) begin // [RULE3] [RULE6]
            arr_req_ff   <= 1'b1;
            arr_erase_ff <= 1'b0;
            arr_addr_ff  <= {addr_ff[15:8], prog_off}; // [RULE4]
            arr_data_ff  <= page_mem[prog_off];
            st_ff        <= S_PWT;
          end else begin
            idx_ff <= idx_ff + 9'h001;
          end
        end
        S_PWT: begin
          if (arr_ack) begin
            arr_req_ff <= 1'b0;
            idx_ff     <= idx_ff + 9'h001;
            st_ff      <= S_PROG;
            if (~arr_ok)
              pe_fail_ff <= 1'b1; // [RULE12]
          end
        end
        S_ERS: begin
          if (arr_ack) begin
            arr_req_ff <= 1'b0;
            st_ff      <= S_TIME;
            if (~arr_ok)
              pe_fail_ff <= 1'b1; // [RULE22]
          end
        end
        S_TIME: begin
          // busy holds for the full cycle time, which a polling host sees
          if (tmr_ff >= tgt_ff) begin // [RULE11]
            busy_ff <= 1'b0;
            st_ff   <= S_RX;
          end
        end
        default: begin
          st_ff      <= S_RX;
          busy_ff    <= 1'b0;
          arr_req_ff <= 1'b0;
        end
      endcase
    end
  end
endmodule // spefe_engine
`default_nettype wire

// ===== tb/spefe_props.sv
// concurrent checks on the ports of the program and erase engine
`timescale 1ns/1ns
`default_nettype none
module spefe_props (
  input wire logic        clock,             // system clock
  input wire logic        sys_rst,           // sync reset
  input wire logic        write_latch_flag,  // latch state
  input wire logic        array_protect_bit, // protect level
  input wire logic        arr_ack,           // array done
  input wire logic        arr_ok,            // array verify result
  input wire logic        wel_clear_ff,      // latch clear pulse
  input wire logic        busy_ff,           // cycle running
  input wire logic        pe_fail_ff,        // failure flag
  input wire logic        arr_req_ff,        // array request
  input wire logic        arr_erase_ff,      // erase request
  input wire logic [1:0]  arr_size_ff,       // erase size code
  input wire logic [15:0] arr_addr_ff        // array address
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_start;
    $rose(busy_ff);
  endsequence
  sequence s_ack_bad;
    arr_req_ff && arr_ack && !arr_ok;
  endsequence
  start_needs_latch_a: assert property (s_start |-> $past(write_latch_flag) && !$past(array_protect_bit))
    else $error("cycle started without latch or while protected");
  start_clears_a: assert property (s_start |-> wel_clear_ff)
    else $error("no latch clear at cycle start");
  clear_pulse_a: assert property (wel_clear_ff |=> !wel_clear_ff)
    else $error("latch clear longer than one cycle");
  clear_latch_a: assert property (wel_clear_ff |-> $past(write_latch_flag))
    else $error("latch clear while latch was low");
  req_busy_a: assert property (arr_req_ff |-> busy_ff)
    else $error("array request outside busy");
  req_hold_a: assert property (arr_req_ff && !arr_ack |=> arr_req_ff && $stable(arr_addr_ff))
    else $error("array request dropped before ack");
  erase_one_a: assert property (arr_req_ff && arr_ack && arr_erase_ff |=> !arr_req_ff [*2])
    else $error("second request after erase");
  erase_mask_a: assert property (arr_req_ff && arr_erase_ff |->
    (arr_size_ff == 2'h0 && arr_addr_ff[7:0] == 8'h00) || (arr_size_ff == 2'h1 && arr_addr_ff[11:0] == 12'h000) ||
    (arr_size_ff == 2'h2 && arr_addr_ff[14:0] == 15'h0000))
    else $error("erase base not masked");
  fail_flag_a: assert property (s_ack_bad |=> pe_fail_ff)
    else $error("failure flag not set");
endmodule // spefe_props
bind spefe_engine spefe_props u_props (.clock(clock), .sys_rst(sys_rst), .write_latch_flag(write_latch_flag),
  .array_protect_bit(array_protect_bit), .arr_ack(arr_ack), .arr_ok(arr_ok), .wel_clear_ff(wel_clear_ff),
  .busy_ff(busy_ff), .pe_fail_ff(pe_fail_ff), .arr_req_ff(arr_req_ff), .arr_erase_ff(arr_erase_ff),
  .arr_size_ff(arr_size_ff), .arr_addr_ff(arr_addr_ff));
`default_nettype wire

// ===== tb/spefe_host.sv
// serial host model sending mode 0 or mode 3 command frames
`timescale 1ns/1ns
`default_nettype none
module spefe_host (
  input  wire logic clock, // system clock
  output var  logic sck,   // serial clock, still outside frames
  output var  logic cs_n,  // chip select
  output var  logic si     // serial data
);
  logic cpol = 1'h0; // 1 selects mode 3: clock idles high
  initial begin
    sck = 1'h0;
    cs_n = 1'h1;
    si = 1'h0;
  end
  // bits go msb first from v[95]; a count off a byte boundary makes a broken frame
  task automatic send(input logic [95:0] v, input int nb);
    int i;
    @(negedge clock);
    sck = cpol;
    @(negedge clock);
    cs_n = 1'h0;
    for (i = 0; i < nb; i++) begin
      sck = 1'h0;
      si = v[95-i];
      repeat (4) @(negedge clock);
      sck = 1'h1;
      repeat (4) @(negedge clock);
    end
    sck = cpol;
    repeat (2) @(negedge clock);
    cs_n = 1'h1;
    si = ~si; // released line must not keep the last bit
    repeat (6) @(negedge clock);
  endtask
endmodule // spefe_host
`default_nettype wire

// ===== tb/tb_spefe_engine.sv
// bench for the program and erase engine
`timescale 1ns/1ns
`default_nettype none
module tb_spefe_engine;
  logic        clock = 1'h0;
  logic        sys_rst = 1'h1;
  logic        write_latch_flag = 1'h0;
  logic        array_protect_bit = 1'h0;
  logic        arr_ack = 1'h0;
  logic        arr_ok = 1'h1;
  wire         sck, cs_n, si, wel_clear_ff, busy_ff, pe_fail_ff, arr_req_ff, arr_erase_ff;
  wire  [1:0]  arr_size_ff;
  wire  [15:0] arr_addr_ff;
  wire  [7:0]  arr_data_ff;
  int          fail_count = 0;
  int          n_compared = 0;
  int          nclr, nbusy, k;
  int          cyc = 0;
  logic [26:0] ops[$];
  logic [7:0]  a;
  // refused frames; latch mask doubles as expected clear pulses
  // the last frame is cut inside its opcode and must not act on the opcode before it
  logic [95:0] av[8] = '{{8'h20, 24'h001234, 64'h0}, {8'h02, 24'h000010, 64'h0}, {8'h02, 24'h10, 8'h11, 56'h0},
                         {8'h52, 24'h001234, 64'h0}, {8'h20, 24'h001234, 64'h0}, {8'h02, 24'h0, 8'h11, 56'h0},
                         {8'h81, 24'h0, 64'h0}, {8'h20, 88'h0}};
  int          anb[8] = '{35, 32, 40, 32, 32, 40, 24, 5};
  logic [7:0]  alt = 8'h4F;
  logic [7:0]  apr = 8'h0C;
  logic [7:0]  eop[4] = '{8'h81, 8'h20, 8'h52, 8'hD8};
  logic [23:0] ead[4] = '{24'hC35A77, 24'hA51234, 24'h009ABC, 24'h007FFF};
  logic [15:0] eex[4] = '{16'h5A00, 16'h1000, 16'h8000, 16'h0000};
  int          ecy[4] = '{60, 80, 80, 80};
  always #25 clock = ~clock;
  spefe_engine #(.BP_CYC(300), .PP_CYC(400), .PE_CYC(60), .BLK_CYC(80)) u_dut (.clock(clock), .sys_rst(sys_rst),
    .sck(sck), .cs_n(cs_n), .si(si), .write_latch_flag(write_latch_flag), .array_protect_bit(array_protect_bit),
    .arr_ack(arr_ack), .arr_ok(arr_ok), .wel_clear_ff(wel_clear_ff), .busy_ff(busy_ff), .pe_fail_ff(pe_fail_ff),
    .arr_req_ff(arr_req_ff), .arr_erase_ff(arr_erase_ff), .arr_size_ff(arr_size_ff), .arr_addr_ff(arr_addr_ff),
    .arr_data_ff(arr_data_ff));
  spefe_host u_host (.clock(clock), .sck(sck), .cs_n(cs_n), .si(si));
  // array answers one cycle into each request; the latch lives here and obeys the clear pulse
  always @(negedge clock) begin
    arr_ack = arr_req_ff && !arr_ack;
    if (wel_clear_ff) begin
      write_latch_flag = 1'h0;
      nclr++;
    end
  end
  always @(posedge clock) begin
    if (busy_ff) nbusy++;
    if (arr_req_ff && arr_ack) ops.push_back({arr_erase_ff, arr_size_ff, arr_addr_ff, arr_data_ff});
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic run(input logic [95:0] v, input int nb, input logic latch, input logic prot, input logic ok);
    int g;
    @(negedge clock);
    write_latch_flag = latch;
    array_protect_bit = prot;
    arr_ok = ok;
    ops.delete();
    nclr = 0;
    nbusy = 0;
    u_host.send(v, nb);
    g = 0;
    while ((busy_ff !== 1'h0 || g < 8) && g < 5000) begin
      @(negedge clock);
      g++;
    end
    check("busy at end", busy_ff, 1'h0);
  endtask
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clock);
    sys_rst = 1'h0;
    repeat (4) @(negedge clock);
    run({8'h02, 24'h0000FE, 24'hD0D1D2, 40'h0}, 56, 1'h1, 1'h0, 1'h1);
    check("program writes", ops.size(), 3);
    for (k = 0; k < 3; k++) begin
      a = 8'hFE + k[7:0];
      check("program op", {ops[k][26], ops[k][23:0]}, {1'h0, 8'h00, a, 8'hD0 + k[7:0]});
    end
    check("program clears", nclr, 1);
    check("page time", nbusy >= 400 && nbusy <= 403, 1);
    u_host.cpol = 1'h1; // mode 3 frame
    run({8'h02, 24'h001234, 8'h5A, 56'h0}, 40, 1'h1, 1'h0, 1'h0);
    u_host.cpol = 1'h0;
    check("byte op", {ops[0][26], ops[0][23:0]}, {1'h0, 16'h1234, 8'h5A});
    check("byte time", nbusy >= 300 && nbusy <= 303, 1);
    check("program fail", pe_fail_ff, 1'h1);
    for (k = 0; k < 4; k++) begin
      run({eop[k], ead[k], 8'hEE, 56'h0}, k == 1 ? 40 : 32, 1'h1, 1'h0, k != 3);
      check("erase count", ops.size(), 1);
      check("erase op", ops[0][26:8], {1'h1, 2'(k > 1 ? 2 : k), eex[k]});
      check("erase clears", nclr, 1);
      check("erase time", nbusy >= ecy[k] && nbusy <= ecy[k] + 3, 1);
      check("erase fail", pe_fail_ff, k == 3);
    end
    for (k = 0; k < 8; k++) begin
      run(av[k], anb[k], alt[k], apr[k], 1'h1);
      check("refused ops", ops.size(), 0);
      check("refused busy", nbusy, 0);
      check("refused clears", nclr, alt[k]);
    end
    give_verdict();
  end
endmodule // tb_spefe_engine
`default_nettype wire
